// File: twug_guard.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - a first key byte write starts a counter watching three machine cycles for the second key byte.
// - the write window opens only when the second key byte comes within three machine cycles.
// - a second key byte arriving later opens nothing and later protected writes fail.
// - an open window lasts until three machine cycle ticks have passed and closes by itself.
// - a protected write takes effect only while the window is open, otherwise it is discarded.
// - the window does not close on a protected write; writes after it closes are rejected.
// - reads of protected registers always pass, window or not.
// - power control, chip control and program trigger registers are protected.
// - boot address and both watchdog control registers are protected.
// - the unlock key register is eight bit write only at c7 and resets to all ones.
module twug_guard
  import twug_pkg::*;
#(
  parameter int unsigned MC_CLKS = MC_CLKS_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output twug_sfr_req_s o_prot,
  output logic o_window_open
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check

  if (MC_CLKS < 1) begin : g_bad_mc
    $error("twug_guard: MC_CLKS must be at least 1");
  end

  // both counters share one width; a count that does not fit would wrap
  if (KEY_GAP_MC < 1 || KEY_GAP_MC >= (1 << MC_CNT_W)) begin : g_bad_gap
    $error("twug_guard: key gap count does not fit its counter");
  end

  if (WINDOW_MC < 1 || WINDOW_MC >= (1 << MC_CNT_W)) begin : g_bad_win
    $error("twug_guard: window count does not fit its counter");
  end

  if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_bus
    $error("twug_guard: bus is built for byte address and data");
  end

  if (PROT_COUNT < 1) begin : g_bad_count
    $error("twug_guard: protected set is empty");
  end

  if (STAT_EXP_BIT >= DATA_W || STAT_REJ_BIT >= DATA_W) begin : g_bad_stat
    $error("twug_guard: status bit outside the byte");
  end

  if (STAT_WIN_BIT == STAT_PEND_BIT ||
      STAT_REJ_BIT == STAT_EXP_BIT) begin : g_bad_map
    $error("twug_guard: status bits overlap");
  end

  if (UNLOCK_KEY_ADDR == GUARD_STATUS_ADDR) begin : g_bad_key
    $error("twug_guard: key and status share an address");
  end

  // a protected address on top of the guard's own would never be gated
  for (genvar gc = 0; gc < PROT_COUNT; gc++) begin : g_map_chk
    if (PROT_ADDR_LIST[gc*8 +: 8] == UNLOCK_KEY_ADDR ||
        PROT_ADDR_LIST[gc*8 +: 8] == GUARD_STATUS_ADDR) begin : g_clash
      $error("twug_guard: protected address clashes with the guard");
    end
  end

  localparam int unsigned PRE_W = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MC_CLKS - 1);
  localparam logic [MC_CNT_W-1:0] GAP_LOAD = MC_CNT_W'(KEY_GAP_MC);
  localparam logic [MC_CNT_W-1:0] WIN_LOAD = MC_CNT_W'(WINDOW_MC);
  localparam logic [MC_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    addr_is = (a == b);
  endfunction

  logic [PROT_COUNT-1:0] prot_hit;

  genvar gi;
  generate
    for (gi = 0; gi < PROT_COUNT; gi++) begin : g_prot
      assign prot_hit[gi] = addr_is(i_addr, PROT_ADDR_LIST[gi*8 +: 8]);
    end
  endgenerate

  wire logic is_prot = |prot_hit;
  wire logic is_key = addr_is(i_addr, UNLOCK_KEY_ADDR);
  wire logic is_stat = addr_is(i_addr, GUARD_STATUS_ADDR);
  wire logic key_wr = i_wr & is_key;
  wire logic key_first = key_wr & (i_wdata == KEY_FIRST);
  wire logic key_second = key_wr & (i_wdata == KEY_SECOND);

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle tick

  // free running, not aligned to key writes: with MC_CLKS above 1
  // the first tick may come early, so gap and window can run short
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  wire logic mc_tick = (pre_r == PRE_LAST);

  assign pre_nxt = mc_tick ? '0 : PRE_W'(pre_r + 1'b1);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key sequence and window

  twug_state_e state_r;
  twug_state_e state_nxt;
  logic [MC_CNT_W-1:0] gap_r;
  logic [MC_CNT_W-1:0] gap_nxt;
  logic [MC_CNT_W-1:0] win_r;
  logic [MC_CNT_W-1:0] win_nxt;
  logic [7:0] key_r;
  logic expired_r;
  logic expired_nxt;

  wire logic gap_done = (gap_r == CNT_ZERO);
  wire logic pending = (state_r == TWUG_ARMED) && !gap_done;
  wire logic win_open = (win_r != CNT_ZERO);
  wire logic win_tick = win_open & mc_tick;
  // last key byte seen must be the first key byte
  wire logic key_armed = (key_r == KEY_FIRST);
  // second key byte only counts inside the gap
  wire logic unlock = key_second & pending & key_armed;

  // window counts machine cycles; protected writes do not touch it
  always_comb begin
    win_nxt = win_r;
    if (unlock) begin
      win_nxt = WIN_LOAD;
    // a fresh unlock while open restarts the full window
    end else if (win_tick) begin
      win_nxt = MC_CNT_W'(win_r - 1'b1);
    end
  end

  always_comb begin
    state_nxt = state_r;
    gap_nxt = gap_r;
    expired_nxt = expired_r;
    case (state_r)
      TWUG_IDLE: begin
        if (key_first) begin
          state_nxt = TWUG_ARMED;
          gap_nxt = GAP_LOAD;
        end
      end
      TWUG_ARMED: begin
        if (unlock) begin
          state_nxt = TWUG_OPEN;
          gap_nxt = CNT_ZERO;
          expired_nxt = 1'b0;
        end else if (key_first) begin
          gap_nxt = GAP_LOAD;
        end else if (key_wr) begin
          // stray value drops the sequence
          state_nxt = TWUG_IDLE;
          gap_nxt = CNT_ZERO;
        end else if (gap_done) begin
          // late second byte finds nothing armed
          state_nxt = TWUG_IDLE;
          expired_nxt = 1'b1;
        end else if (mc_tick) begin
          gap_nxt = MC_CNT_W'(gap_r - 1'b1);
        end
      end
      TWUG_OPEN: begin
        // new sequence armed, running window keeps going
        if (key_first) begin
          state_nxt = TWUG_ARMED;
          gap_nxt = GAP_LOAD;
        end else if (!win_open) begin
          state_nxt = TWUG_IDLE;
        end
      end
      default: begin
        state_nxt = TWUG_IDLE;
        gap_nxt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= TWUG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_r <= CNT_ZERO;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      win_r <= CNT_ZERO;
    end else begin
      win_r <= win_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= expired_nxt;
    end
  end

  // key register holds the last key byte written; unlock needs it to be the first key byte
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_r <= UNLOCK_KEY_RESET;
    end else if (key_wr) begin
      key_r <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protected write gate

  // reads pass untouched; only the write strobe is gated
  wire logic prot_wr_try = i_wr & is_prot;
  wire logic prot_wr_ok = prot_wr_try & win_open;
  wire logic prot_wr_drop = prot_wr_try & ~win_open;

  // combinational so the protected write lands in its own cycle
  assign o_prot.addr = i_addr;
  assign o_prot.data = i_wdata;
  assign o_prot.wr = prot_wr_ok;
  assign o_prot.rd = i_rd;
  assign o_window_open = win_open;

  ////////////////////////////////////////////////////////////////////////////
  // status and read back

  logic reject_r;
  logic reject_nxt;
  wire logic stat_rd = i_rd & is_stat;

  // new reject wins over the clearing read
  assign reject_nxt = prot_wr_drop | (reject_r & ~stat_rd);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reject_r <= 1'b0;
    end else begin
      reject_r <= reject_nxt;
    end
  end

  // bit1 second key awaited, bit2 write dropped, bit3 sequence expired
  logic [7:0] status_word;
  logic [7:0] rdata_nxt;

  always_comb begin
    status_word = BYTE_ZERO;
    status_word[STAT_WIN_BIT] = win_open;
    status_word[STAT_PEND_BIT] = pending;
    status_word[STAT_REJ_BIT] = reject_r;
    status_word[STAT_EXP_BIT] = expired_r;
  end

  // key register is write only and reads as zero
  assign rdata_nxt = (i_rd && is_stat) ? status_word : BYTE_ZERO;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= BYTE_ZERO;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

endmodule // twug_guard
`default_nettype wire

// File: twug_guard_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module twug_guard_asserts
  import twug_pkg::*;
#(parameter int unsigned MC_CLKS = MC_CLKS_DEFAULT) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire twug_sfr_req_s o_prot,
  input wire logic o_window_open
);
  // fixed delays assume one clock per machine cycle
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  function automatic logic isp(input logic [7:0] a);
    isp = 1'b0;
    for (int k = 0; k < PROT_COUNT; k++)
      if (PROT_ADDR_LIST[k*8+:8] == a) isp = 1'b1;
  endfunction
  wire kwr = i_wr && i_addr == UNLOCK_KEY_ADDR;
  wire kaa = kwr && i_wdata == KEY_FIRST;
  wire k55 = kwr && i_wdata == KEY_SECOND;
  wire kbad = kwr && !kaa && !k55;
  wire krd = i_rd && i_addr == UNLOCK_KEY_ADDR;
  wire pwr = i_wr && isp(i_addr);
  logic [7:0] s55_r, saa_r;
  wire late = k55 && saa_r >= 8'(3 * MC_CLKS);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s55_r <= 8'hff;
      saa_r <= 8'hff;
    end else begin
      // ages saturate so a stale key never looks fresh
      s55_r <= k55 ? 8'h00 : s55_r + 8'(s55_r != 8'hff);
      saa_r <= kaa ? 8'h00 : saa_r + 8'(saa_r != 8'hff);
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_unlock; kaa ##1 k55; endsequence
  sequence s_drop; kaa ##1 kbad ##1 k55; endsequence
  AST_GATE: assert property (o_prot.wr |-> pwr && o_window_open)
    else $error("write outside window");
  AST_PASS: assert property (pwr && o_window_open |-> o_prot.wr)
    else $error("write lost in window");
  AST_READ: assert property (i_rd |-> o_prot.rd && o_prot.addr == i_addr)
    else $error("read blocked");
  AST_FWD: assert property (i_wr |-> o_prot.data == i_wdata)
    else $error("write data lost");
  AST_OPEN: assert property (s_unlock |=> o_window_open [*3])
    else $error("window short");
  AST_SHUT: assert property (o_window_open |-> s55_r < 8'(3 * MC_CLKS))
    else $error("window long");
  AST_LATE: assert property (late && !o_window_open |=> !o_window_open)
    else $error("late key opened");
  AST_DROP: assert property ((!o_window_open throughout s_drop)
    |=> !o_window_open) else $error("abandoned key opened");
  AST_KEYRD: assert property (krd |=> o_rdata == 8'h00)
    else $error("key reg readable");
endmodule // twug_guard_asserts
`default_nettype wire

// File: twug_guard_tb.sv
`timescale 1ns/100ps
`default_nettype none
module twug_guard_tb
  import twug_pkg::*;
;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic o_window_open, rd_d = 1'b0;
  twug_sfr_req_s o_prot;
  logic [31:0] lfsr = 32'hb339;
  int mismatches = 0, n_checks = 0;
  logic q_wr[$];
  logic [7:0] q_rd[$];
  twug_guard uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_prot(o_prot), .o_window_open(o_window_open));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] pa(input int k);
    return PROT_ADDR_LIST[(k % PROT_COUNT)*8+:8];
  endfunction
  // every write expects a gate value, key writes expect zero
  task automatic bus(input logic w, input logic [7:0] a, d, input logic e);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    if (w)
      q_wr.push_back(e);
    else
      q_rd.push_back(d);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
    end
  endtask
  task automatic chk_wr();
    logic e;
    e = (q_wr.size() != 0) ? q_wr.pop_front() : 1'bx;
    n_checks++;
    if (o_prot.wr !== e) begin
      mismatches++;
      $display("mismatch %0t gated write %b", $time, o_prot.wr);
    end
  endtask
  task automatic chk_rd();
    logic [7:0] e;
    e = (q_rd.size() != 0) ? q_rd.pop_front() : 8'hxx;
    n_checks++;
    if (o_rdata !== e) begin
      mismatches++;
      $display("mismatch %0t read data %h", $time, o_rdata);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // sampled mid-cycle, after the launching edge has settled
  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk) begin
    if (i_wr)
      chk_wr();
    if (rd_d)
      chk_rd();
  end
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int k = 0; k < PROT_COUNT; k++) begin
      bus(1'b1, pa(k), rnd(), 1'b0);
      bus(1'b0, pa(k), 8'h00, 1'b0);
    end
    bus(1'b0, UNLOCK_KEY_ADDR, 8'h00, 1'b0);
    bus(1'b0, 8'h00, 8'h00, 1'b0);
    // gaps 0..3, then an abandoned sequence
    for (int g = 0; g < 5; g++) begin
      for (int k = 0; k < PROT_COUNT; k++) begin
        bus(1'b1, UNLOCK_KEY_ADDR, KEY_FIRST, 1'b0);
        if (g == 4)
          bus(1'b1, UNLOCK_KEY_ADDR, rnd() & 8'h0f, 1'b0);
        idle(g % 4);
        bus(1'b1, UNLOCK_KEY_ADDR, KEY_SECOND, 1'b0);
        for (int j = 0; j < 4; j++)
          bus(1'b1, pa(k + j), rnd(), g < 3 && j < 3);
        // last write always dropped: reject flag set, then cleared by read
        bus(1'b0, GUARD_STATUS_ADDR, 8'h01 << STAT_REJ_BIT, 1'b0);
        bus(1'b0, GUARD_STATUS_ADDR, 8'h00, 1'b0);
        idle(4);
      end
    end
    // first key alone: pending, then expired once the gap runs out
    bus(1'b1, UNLOCK_KEY_ADDR, KEY_FIRST, 1'b0);
    bus(1'b0, GUARD_STATUS_ADDR, 8'h01 << STAT_PEND_BIT, 1'b0);
    idle(2 + KEY_GAP_MC);
    bus(1'b0, GUARD_STATUS_ADDR, 8'h01 << STAT_EXP_BIT, 1'b0);
    idle(2);
    end_of_test();
  end
endmodule // twug_guard_tb
bind twug_guard twug_guard_asserts #(.MC_CLKS(MC_CLKS)) u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_prot(o_prot), .o_window_open(o_window_open));
`default_nettype wire

// File: twug_pkg.sv
package twug_pkg;

  // sfr address space
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // unlock key register
  localparam logic [7:0] UNLOCK_KEY_ADDR = 8'hc7;
  localparam logic [7:0] UNLOCK_KEY_RESET = 8'hff;
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // guard status register, read only
  localparam logic [7:0] GUARD_STATUS_ADDR = 8'hc6;
  localparam int unsigned STAT_WIN_BIT = 0;
  localparam int unsigned STAT_PEND_BIT = 1;
  localparam int unsigned STAT_REJ_BIT = 2;
  localparam int unsigned STAT_EXP_BIT = 3;

  // protected special function registers
  localparam int unsigned PROT_COUNT = 6;
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'ha3;
  localparam logic [7:0] CHIP_CONTROL_ADDR = 8'h9f;
  localparam logic [7:0] PROGRAM_TRIGGER_ADDR = 8'ha4;
  localparam logic [7:0] BOOT_ADDRESS_ADDR = 8'h9c;
  localparam logic [7:0] WATCHDOG_A_ADDR = 8'hd8;
  localparam logic [7:0] WATCHDOG_B_ADDR = 8'hab;
  localparam logic [PROT_COUNT*8-1:0] PROT_ADDR_LIST = {
    POWER_CONTROL_ADDR, CHIP_CONTROL_ADDR, PROGRAM_TRIGGER_ADDR,
    BOOT_ADDRESS_ADDR, WATCHDOG_A_ADDR, WATCHDOG_B_ADDR};

  // timing, in machine cycles
  localparam int unsigned KEY_GAP_MC = 3;
  localparam int unsigned WINDOW_MC = 3;
  localparam int unsigned MC_CNT_W = 2;
  localparam int unsigned MC_CLKS_DEFAULT = 1;

  // forwarded access towards the protected register file
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic wr;
    logic rd;
  } twug_sfr_req_s;

  typedef enum logic [1:0] {
    TWUG_IDLE,
    TWUG_ARMED,
    TWUG_OPEN
  } twug_state_e;

endpackage
